/* verilog/tcb_pkg.sv */
/*
 * Shared constants and types for the three-channel timer glue block:
 * register offsets, field positions, reset values and prescaler ratios.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package tcb_pkg;
   localparam int NCHAN = 3;
   localparam int NFLAG = 8;
   // Per-channel registers sit at base + n * stride
   localparam logic [7:0] CHAN_STRIDE = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_IRQ_SET = 8'h24;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h28;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
   localparam logic [7:0] OFS_CLK_SEL = 8'h04;
   // Block-wide registers
   localparam logic [7:0] OFS_SYNC = 8'hC0;
   localparam logic [7:0] OFS_ROUTE = 8'hC4;
   localparam logic [7:0] OFS_EVT_STAT = 8'hD0;
   localparam logic [7:0] OFS_EVT_MASK = 8'hD4;
   // Flag positions shared by status, enable, disable and mask
   localparam int FLAG_OVERFLOW = 0;
   localparam int FLAG_LOAD_OVR = 1;
   localparam int FLAG_CMP_A = 2;
   localparam int FLAG_CMP_B = 3;
   localparam int FLAG_CMP_C = 4;
   localparam int FLAG_CAP_A = 5;
   localparam int FLAG_CAP_B = 6;
   localparam int FLAG_EXT_TRIG = 7;
   localparam int SYNC_BIT = 0;
   // Routing field positions, two bits each
   localparam int ROUTE_IN0_LSB = 0;
   localparam int ROUTE_IN1_LSB = 2;
   localparam int ROUTE_IN2_LSB = 4;
   localparam int ROUTE_W = 6;
   localparam int CLKSEL_W = 3;
   // Reset values
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [5:0] ROUTE_RST = 6'h00;
   localparam logic [2:0] CLKSEL_RST = 3'h0;
   // Prescaler ratios of internal sources 2..5
   localparam int DIV_A = 2;
   localparam int DIV_B = 8;
   localparam int DIV_C = 32;
   localparam int DIV_D = 128;
   localparam int PRESC_W = 7;

   typedef enum logic [1:0] {
      TCB_SRC_PIN = 2'h0,
      TCB_SRC_NONE = 2'h1,
      TCB_SRC_OUTA_LO = 2'h2,
      TCB_SRC_OUTA_HI = 2'h3
   } tcb_route_t;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
   } tcb_req_t;

   typedef struct packed {
      logic [7:0] overflow_etc;
   } tcb_flags_t;
endpackage : tcb_pkg

/* verilog/tcb_prescaler.sv */
/*
 * Internal clock source generator: one-cycle enable ticks for the slow
 * oscillator and for the bus clock divided by 2, 8, 32 and 128.
 * Assumes the slow oscillator arrives asynchronously on a pin.
 */
`timescale 1ns/1ps
module tcb_prescaler (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_slow_osc_clock,
   output logic [4:0] o_tick
);
   logic [tcb_pkg::PRESC_W-1:0] cnt_r, cnt_nxt;
   logic [2:0] osc_sync_r, osc_sync_nxt;
   logic osc_lvl_r, osc_lvl_nxt;
   logic [4:0] tick_r, tick_nxt;

   function automatic logic div_hit(input logic [6:0] c, input int d);
      div_hit = (c & 7'((d - 1))) == 7'((d - 1));
   endfunction : div_hit

   // Free counter; each ratio ticks when its low bits wrap
   always_comb begin
      cnt_nxt = cnt_r + 7'h01;
      osc_sync_nxt = {osc_sync_r[1:0], i_slow_osc_clock};
      // Level only follows once stages two and three agree
      osc_lvl_nxt = (osc_sync_r[1] == osc_sync_r[2]) ? osc_sync_r[2]
                                                     : osc_lvl_r;
      tick_nxt[0] = osc_lvl_nxt & ~osc_lvl_r; // [R10]
      tick_nxt[1] = div_hit(cnt_r, tcb_pkg::DIV_A); // [R11]
      tick_nxt[2] = div_hit(cnt_r, tcb_pkg::DIV_B); // [R11]
      tick_nxt[3] = div_hit(cnt_r, tcb_pkg::DIV_C); // [R11]
      tick_nxt[4] = div_hit(cnt_r, tcb_pkg::DIV_D); // [R11]
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 7'h00;
         osc_sync_r <= 3'h0;
         osc_lvl_r <= 1'b0;
         tick_r <= 5'h00;
      end else begin
         cnt_r <= cnt_nxt;
         osc_sync_r <= osc_sync_nxt;
         osc_lvl_r <= osc_lvl_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign o_tick = tick_r;
endmodule : tcb_prescaler

/* verilog/tcb_top.sv */
/*
 * Timer block glue: per-channel interrupt masks and status flags, block
 * sync trigger, external clock routing and per-channel clock selection,
 * all behind an APB slave. Assumes the counter datapath of each channel
 * sits outside and supplies event pulses and output A levels on i_clk.
 */
// Functional notes
// (R1) Writing ones to a channel's enable-set register sets those mask bits.
// (R2) Writing ones to a channel's disable-clear register clears those bits.
// (R3) A mask bit at one enables its source; the mask reads only, resets 0.
// (R4) Enable, disable and mask share one eight-flag layout, trigger at 7.
// (R5) Writing one to bit 0 of sync control pulses a trigger to all channels.
// (R6) Routing field 2 picks pin 2, nothing, chan0 out A or chan1 out A.
// (R7) Routing field 1 picks pin 1, nothing, chan0 out A or chan2 out A.
// (R8) Routing field 0 picks pin 0, nothing, chan1 out A or chan2 out A.
// (R9) Each channel picks its own internal or external clock source.
// (R10) Internal source 1 is the slow oscillator clock.
// (R11) Internal sources 2 to 5 are the bus clock over 2, 8, 32 and 128.
// (R12) Reading a channel's status register clears its pending flags.
// (R13) The overflow flag sets on counter overflow, clears on status read.
// (R14) A channel interrupt is high while any flag is set with its mask on.
`timescale 1ns/1ps
module tcb_top (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [23:0] i_chan_events,
   input wire logic [2:0] i_chan_output_a,
   input wire logic [2:0] i_ext_clock_pin,
   input wire logic i_slow_osc_clock,
   output logic [2:0] o_chan_irq,
   output logic o_sync_trigger,
   output logic [2:0] o_ext_clock_input,
   output logic [2:0] o_chan_clk_tick,
   output logic o_irq
);
   localparam int NC = tcb_pkg::NCHAN;
   localparam int NF = tcb_pkg::NFLAG;

   tcb_pkg::tcb_req_t req;
   logic [NF-1:0] mask_r [NC], mask_nxt [NC];
   logic [NF-1:0] stat_r [NC], stat_nxt [NC];
   logic [tcb_pkg::CLKSEL_W-1:0] csel_r [NC], csel_nxt [NC];
   logic [tcb_pkg::ROUTE_W-1:0] route_r, route_nxt;
   logic [2:0] evt_stat_r, evt_stat_nxt;
   logic [2:0] evt_mask_r, evt_mask_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic err_r, err_nxt;
   logic sync_r, sync_nxt;
   logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r, pin_lvl_nxt;
   logic [2:0] pin_s1_nxt, pin_s2_nxt, pin_s3_nxt;
   logic [2:0] xin_r, xin_nxt, xin_d_r;
   logic [2:0] irq_r, irq_nxt, irq_d_r;
   logic [2:0] tick_r, tick_nxt;
   logic [4:0] int_tick;
   logic setup, access, wr_acc, rd_acc;

   // Offset of a channel register
   function automatic logic [7:0] chan_ofs(input int n, input logic [7:0] b);
      chan_ofs = 8'(n) * tcb_pkg::CHAN_STRIDE + b;
   endfunction : chan_ofs

   // Route one external clock input from its two-bit selector
   function automatic logic route_pick(input logic [1:0] sel,
                                       input logic pin,
                                       input logic lo, input logic hi);
      case (tcb_pkg::tcb_route_t'(sel))
         tcb_pkg::TCB_SRC_PIN: route_pick = pin;
         tcb_pkg::TCB_SRC_OUTA_LO: route_pick = lo;
         tcb_pkg::TCB_SRC_OUTA_HI: route_pick = hi;
         default: route_pick = 1'b0;
      endcase
   endfunction : route_pick

   // Does the address hit any mapped register?
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == tcb_pkg::OFS_SYNC) || (a == tcb_pkg::OFS_ROUTE) ||
                 (a == tcb_pkg::OFS_EVT_STAT) ||
                 (a == tcb_pkg::OFS_EVT_MASK);
      for (int n = 0; n < NC; n++) begin
         addr_hit = addr_hit ||
                    (a == chan_ofs(n, tcb_pkg::OFS_STATUS)) ||
                    (a == chan_ofs(n, tcb_pkg::OFS_IRQ_SET)) ||
                    (a == chan_ofs(n, tcb_pkg::OFS_IRQ_CLR)) ||
                    (a == chan_ofs(n, tcb_pkg::OFS_IRQ_MASK)) ||
                    (a == chan_ofs(n, tcb_pkg::OFS_CLK_SEL));
      end
   endfunction : addr_hit

   assign req = '{addr: i_paddr, write: i_pwrite, wdata: i_pwdata};
   assign setup = i_psel & ~i_penable;
   assign access = i_psel & i_penable;
   assign wr_acc = access & req.write & ~err_r;
   assign rd_acc = access & ~req.write & ~err_r;

   // One shared divider keeps every channel's internal sources in phase
   tcb_prescaler u_presc (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_slow_osc_clock(i_slow_osc_clock),
      .o_tick(int_tick)
   );

   // Read data is fetched in setup so it comes from a flop in access
   always_comb begin
      rdata_nxt = rdata_r;
      err_nxt = err_r;
      if (setup) begin
         rdata_nxt = 32'h0000_0000;
         err_nxt = ~addr_hit(req.addr);
         if (req.addr == tcb_pkg::OFS_ROUTE)
            rdata_nxt[tcb_pkg::ROUTE_W-1:0] = route_r;
         if (req.addr == tcb_pkg::OFS_EVT_STAT)
            rdata_nxt[2:0] = evt_stat_r;
         if (req.addr == tcb_pkg::OFS_EVT_MASK)
            rdata_nxt[2:0] = evt_mask_r;
         for (int n = 0; n < NC; n++) begin
            if (req.addr == chan_ofs(n, tcb_pkg::OFS_IRQ_MASK))
               rdata_nxt[NF-1:0] = mask_r[n]; // [R3] [R4]
            if (req.addr == chan_ofs(n, tcb_pkg::OFS_STATUS))
               rdata_nxt[NF-1:0] = stat_r[n];
            if (req.addr == chan_ofs(n, tcb_pkg::OFS_CLK_SEL))
               rdata_nxt[tcb_pkg::CLKSEL_W-1:0] = csel_r[n];
         end
      end
   end

   // Channel mask and status flags
   always_comb begin
      for (int n = 0; n < NC; n++) begin
         mask_nxt[n] = mask_r[n];
         stat_nxt[n] = stat_r[n];
         if (wr_acc && req.addr == chan_ofs(n, tcb_pkg::OFS_IRQ_SET))
            mask_nxt[n] = mask_r[n] | req.wdata[NF-1:0]; // [R1] [R4]
         if (wr_acc && req.addr == chan_ofs(n, tcb_pkg::OFS_IRQ_CLR))
            mask_nxt[n] = mask_r[n] & ~req.wdata[NF-1:0]; // [R2] [R4]
         // Clear only what the read reported: a flag raised after the
         // setup edge was not seen, so it stays pending for the next read
         if (rd_acc && req.addr == chan_ofs(n, tcb_pkg::OFS_STATUS))
            stat_nxt[n] = stat_r[n] & ~rdata_r[NF-1:0]; // [R12] [R13]
         // A flag arriving in the same cycle still sets
         stat_nxt[n] = stat_nxt[n] | i_chan_events[n*NF +: NF]; // [R13]
      end
   end

   // Per-channel clock source select
   always_comb begin
      for (int n = 0; n < NC; n++) begin
         csel_nxt[n] = csel_r[n];
         if (wr_acc && req.addr == chan_ofs(n, tcb_pkg::OFS_CLK_SEL))
            csel_nxt[n] = req.wdata[tcb_pkg::CLKSEL_W-1:0]; // [R9]
      end
   end

   // Block configuration registers and the sync pulse
   always_comb begin
      route_nxt = route_r;
      evt_mask_nxt = evt_mask_r;
      sync_nxt = 1'b0;
      if (wr_acc && req.addr == tcb_pkg::OFS_ROUTE)
         route_nxt = req.wdata[tcb_pkg::ROUTE_W-1:0];
      if (wr_acc && req.addr == tcb_pkg::OFS_EVT_MASK)
         evt_mask_nxt = req.wdata[2:0];
      if (wr_acc && req.addr == tcb_pkg::OFS_SYNC)
         sync_nxt = req.wdata[tcb_pkg::SYNC_BIT]; // [R5]
   end

   // Block event status: sticky on a rising channel request
   always_comb begin
      evt_stat_nxt = evt_stat_r;
      if (wr_acc && req.addr == tcb_pkg::OFS_EVT_STAT)
         evt_stat_nxt = evt_stat_r & ~req.wdata[2:0];
      // Set beats clear, so a request rising under the write is kept
      evt_stat_nxt = evt_stat_nxt | (irq_r & ~irq_d_r);
   end

   // Channel interrupt requests from flags gated by mask
   always_comb begin
      for (int n = 0; n < NC; n++)
         irq_nxt[n] = |(stat_nxt[n] & mask_nxt[n]); // [R3] [R14]
   end

   // External pin filter: stages two and three must agree
   always_comb begin
      pin_s1_nxt = i_ext_clock_pin;
      pin_s2_nxt = pin_s1_r;
      pin_s3_nxt = pin_s2_r;
      for (int k = 0; k < 3; k++)
         pin_lvl_nxt[k] = (pin_s2_r[k] == pin_s3_r[k]) ? pin_s3_r[k]
                                                        : pin_lvl_r[k];
      xin_nxt[0] = route_pick(route_r[tcb_pkg::ROUTE_IN0_LSB +: 2],
                              pin_lvl_r[0], i_chan_output_a[1],
                              i_chan_output_a[2]); // [R8]
      xin_nxt[1] = route_pick(route_r[tcb_pkg::ROUTE_IN1_LSB +: 2],
                              pin_lvl_r[1], i_chan_output_a[0],
                              i_chan_output_a[2]); // [R7]
      xin_nxt[2] = route_pick(route_r[tcb_pkg::ROUTE_IN2_LSB +: 2],
                              pin_lvl_r[2], i_chan_output_a[0],
                              i_chan_output_a[1]); // [R6]
   end

   // Per-channel counting tick: internal 0..4 or external edge 5..7
   // External edges come one cycle after the routed level changes
   always_comb begin
      for (int n = 0; n < NC; n++) begin
         case (csel_r[n])
            3'h0, 3'h1, 3'h2, 3'h3, 3'h4:
               tick_nxt[n] = int_tick[csel_r[n]]; // [R9] [R10] [R11]
            3'h5: tick_nxt[n] = xin_r[0] & ~xin_d_r[0]; // [R9]
            3'h6: tick_nxt[n] = xin_r[1] & ~xin_d_r[1];
            3'h7: tick_nxt[n] = xin_r[2] & ~xin_d_r[2];
            default: tick_nxt[n] = 1'b0;
         endcase
      end
   end

   // Channel registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int n = 0; n < NC; n++) begin
            mask_r[n] <= tcb_pkg::MASK_RST;
            stat_r[n] <= 8'h00;
            csel_r[n] <= tcb_pkg::CLKSEL_RST;
         end
      end else begin
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         csel_r <= csel_nxt;
      end
   end

   // Bus capture: read data and address error from the setup cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
      end
   end

   // Block registers and sync pulse
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         route_r <= tcb_pkg::ROUTE_RST;
         evt_stat_r <= 3'h0;
         evt_mask_r <= 3'h0;
         sync_r <= 1'b0;
      end else begin
         route_r <= route_nxt;
         evt_stat_r <= evt_stat_nxt;
         evt_mask_r <= evt_mask_nxt;
         sync_r <= sync_nxt;
      end
   end

   // Pin chain and routed inputs; all clear to the idle low level, so
   // no false edge follows reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_s1_r <= 3'h0;
         pin_s2_r <= 3'h0;
         pin_s3_r <= 3'h0;
         pin_lvl_r <= 3'h0;
         xin_r <= 3'h0;
         xin_d_r <= 3'h0;
      end else begin
         pin_s1_r <= pin_s1_nxt;
         pin_s2_r <= pin_s2_nxt;
         pin_s3_r <= pin_s3_nxt;
         pin_lvl_r <= pin_lvl_nxt;
         xin_r <= xin_nxt;
         xin_d_r <= xin_r;
      end
   end

   // Interrupt levels, their delayed copy and the count ticks
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_r <= 3'h0;
         irq_d_r <= 3'h0;
         tick_r <= 3'h0;
      end else begin
         irq_r <= irq_nxt;
         irq_d_r <= irq_r;
         tick_r <= tick_nxt;
      end
   end

   // Zero wait: read data already captured during setup
   assign o_prdata = rdata_r;
   assign o_pready = 1'b1;
   assign o_pslverr = access & err_r;
   assign o_chan_irq = irq_r;
   assign o_sync_trigger = sync_r; // [R5]
   assign o_ext_clock_input = xin_r;
   assign o_chan_clk_tick = tick_r;
   assign o_irq = |(evt_stat_r & evt_mask_r);
endmodule : tcb_top

/* bench/tcb_top_assertions.sv */
/*
 * Checker for tcb_top: sync pulse, channel 0 interrupt, clock routing.
 * Assumes it is bound into tcb_top and that pready is held high.
 */
`timescale 1ns/1ps
module tcb_top_assertions (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [23:0] i_chan_events,
   input wire logic [2:0] i_chan_output_a,
   input wire logic [2:0] o_chan_irq,
   input wire logic o_sync_trigger,
   input wire logic [2:0] o_ext_clock_input
);
   logic acc;
   logic rd_st;
   logic clr0;
   logic [7:0] msk_r;
   logic [5:0] rt_r;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // Access edge decodes; zero wait states so no pready term
   assign acc = i_psel & i_penable;
   assign rd_st = acc & ~i_pwrite & (i_paddr == 8'h20);
   assign clr0 = acc & i_pwrite & (i_paddr == 8'h28);
   // Shadow of channel 0 mask and routing, written at the access edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         msk_r <= 8'h00;
         rt_r <= 6'h00;
      end else if (acc && i_pwrite) begin
         if (i_paddr == 8'h24) msk_r <= msk_r | i_pwdata[7:0];
         if (i_paddr == 8'h28) msk_r <= msk_r & ~i_pwdata[7:0];
         if (i_paddr == 8'hC4) rt_r <= i_pwdata[5:0];
      end
   end
   sequence s_sync_wr;
      acc && i_pwrite && i_paddr == 8'hC0 && i_pwdata[0];
   endsequence
   sequence s_pulse;
      o_sync_trigger ##1 !o_sync_trigger;
   endsequence
   property p_sync_pulse;
      s_sync_wr |=> s_pulse;
   endproperty
   a_sync_pulse: assert property (p_sync_pulse)
      else $error("sync write gave no single pulse");
   property p_sync_cause;
      o_sync_trigger |-> $past(acc && i_pwrite && i_paddr == 8'hC0 &&
         i_pwdata[0]);
   endproperty
   a_sync_cause: assert property (p_sync_cause)
      else $error("sync pulse without a sync write");
   property p_irq_masked;
      msk_r == 8'h00 |-> !o_chan_irq[0];
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("channel irq with empty mask");
   property p_irq_set;
      i_chan_events[0] && msk_r[0] && !clr0 |=> o_chan_irq[0];
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("overflow did not raise channel irq");
   property p_irq_hold;
      o_chan_irq[0] && !rd_st && !clr0 |=> o_chan_irq[0];
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("channel irq dropped without cause");
   property p_irq_rdclr;
      rd_st && i_chan_events[7:0] == 8'h00 &&
         $past(i_chan_events[7:0]) == 8'h00 |=> !o_chan_irq[0];
   endproperty
   a_irq_rdclr: assert property (p_irq_rdclr)
      else $error("status read left channel irq high");
   property p_route_none;
      (rt_r[5:4] == 2'h1) [*3] |-> !o_ext_clock_input[2];
   endproperty
   a_route_none: assert property (p_route_none)
      else $error("unrouted input two not low");
   property p_route_in2;
      (rt_r[5:4] == 2'h2 && i_chan_output_a[0]) [*4] |->
         o_ext_clock_input[2];
   endproperty
   a_route_in2: assert property (p_route_in2)
      else $error("input two does not follow channel 0");
   property p_route_in1;
      (rt_r[3:2] == 2'h2 && i_chan_output_a[0]) [*4] |->
         o_ext_clock_input[1];
   endproperty
   a_route_in1: assert property (p_route_in1)
      else $error("input one does not follow channel 0");
   property p_route_in0;
      (rt_r[1:0] == 2'h3 && !i_chan_output_a[2]) [*4] |->
         !o_ext_clock_input[0];
   endproperty
   a_route_in0: assert property (p_route_in0)
      else $error("input zero does not follow channel 2");
endmodule : tcb_top_assertions

bind tcb_top tcb_top_assertions i_chk (.i_clk, .i_rst_n, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_chan_events,
   .i_chan_output_a, .o_chan_irq, .o_sync_trigger, .o_ext_clock_input);

/* bench/tcb_top_tb.sv */
/*
 * Self-checking bench for tcb_top, driven over APB.
 * Assumes a zero-wait slave and a 100 ns clock.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tcb_top_tb;
   logic i_clk, i_rst_n = 1'b0, i_slow_osc_clock = 1'b0;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic [23:0] i_chan_events = 24'h0;
   logic [2:0] i_chan_output_a = 3'h0, i_ext_clock_pin = 3'h0;
   logic o_pready, o_pslverr, o_sync_trigger, o_irq, err;
   logic [2:0] o_chan_irq, o_ext_clock_input, o_chan_clk_tick;
   logic [3:0] oc = 4'h0;
   int fails = 0, checks = 0, syncs = 0, tk [3];

   tcb_top i_tcb_top (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
      .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
      .i_chan_events, .i_chan_output_a, .i_ext_clock_pin,
      .i_slow_osc_clock, .o_chan_irq, .o_sync_trigger,
      .o_ext_clock_input, .o_chan_clk_tick, .o_irq);

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // Stand-in slow oscillator, 16 cycles a period; counts sync pulses
   always @(posedge i_clk) begin
      oc <= oc + 4'h1;
      i_slow_osc_clock <= oc[3];
      if (o_sync_trigger === 1'b1) syncs++;
   end
   // One transfer; request held until pready is seen high
   task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
      input string n);
      apb(a, 1'b0, 32'h0);
      `CHK(n, e, rd)
   endtask : rdc
   // Let the edge's updates land before looking
   task automatic settle;
      @(posedge i_clk);
      #1;
   endtask : settle
   // One-cycle event pulse, then time for the irq chain to respond
   task automatic ev(input logic [23:0] v);
      @(posedge i_clk);
      i_chan_events <= v;
      @(posedge i_clk);
      i_chan_events <= 24'h0;
      repeat (3) @(posedge i_clk);
      #1;
   endtask : ev
   function automatic logic [2:0] exp_rt(input int v,
      input logic [2:0] a, input logic [2:0] k);
      logic [3:0] s0, s1, s2;
      s0 = {a[2], a[1], 1'b0, k[0]};
      s1 = {a[2], a[0], 1'b0, k[1]};
      s2 = {a[1], a[0], 1'b0, k[2]};
      return {s2[v], s1[v], s0[v]};
   endfunction : exp_rt
   task automatic wrap_up;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   // Whole run is near 1400 cycles
   initial begin
      #3000000;
      fails++;
      wrap_up();
   end

   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (int c = 0; c < 3; c++)
         rdc(8'(8'h2C + 8'h40 * c), 32'h0, "mask rst");
      rdc(8'hC4, 32'h0, "route rst");
      // Set walk on channel 1; high bits must be ignored
      for (int b = 0; b < 8; b++) begin
         wr(8'h64, 32'hFFFFFF00 | (32'h1 << b));
         rdc(8'h6C, (32'h1 << (b + 1)) - 32'h1, "mask set");
      end
      wr(8'h6C, 32'h0);
      rdc(8'h6C, 32'hFF, "mask ro");
      rdc(8'h2C, 32'h0, "mask ch0");
      for (int b = 0; b < 8; b++) begin
         wr(8'h68, 32'h1 << b);
         rdc(8'h6C, (32'hFF << (b + 1)) & 32'hFF, "mask clr");
      end
      // Channel 0 interrupt: masked, raised, block masked, cleared
      wr(8'h24, 32'h1);
      ev(24'h000002);
      `CHK("irq masked", 3'h0, o_chan_irq)
      ev(24'h000001);
      `CHK("irq set", 3'h1, o_chan_irq)
      `CHK("blk irq off", 1'b0, o_irq)
      wr(8'hD4, 32'h1);
      settle;
      `CHK("blk irq on", 1'b1, o_irq)
      wr(8'h28, 32'h1);
      settle;
      `CHK("irq off", 3'h0, o_chan_irq)
      wr(8'h24, 32'h1);
      settle;
      `CHK("irq back", 3'h1, o_chan_irq)
      rdc(8'h20, 32'h3, "status");
      settle;
      `CHK("irq rdclr", 3'h0, o_chan_irq)
      rdc(8'h20, 32'h0, "status clr");
      wr(8'hD0, 32'h1);
      settle;
      `CHK("blk irq clr", 1'b0, o_irq)
      // Sync: a zero in bit 0 must not pulse
      wr(8'hC0, 32'hFFFFFFFE);
      wr(8'hC0, 32'h1);
      settle;
      `CHK("sync pulses", 1, syncs)
      // Every routing code on all three inputs, two input patterns
      for (int v = 0; v < 4; v++)
         for (int p = 0; p < 2; p++) begin
            wr(8'hC4, {26'h0, 2'(v), 2'(v), 2'(v)});
            i_chan_output_a <= p ? 3'h2 : 3'h5;
            i_ext_clock_pin <= p ? 3'h5 : 3'h2;
            repeat (8) @(posedge i_clk);
            #1;
            `CHK("route", exp_rt(v, i_chan_output_a, i_ext_clock_pin),
               o_ext_clock_input)
         end
      rdc(8'hC4, 32'h3F, "route rb");
      // Channel 0 walks the dividers, 1 on a dead input, 2 on slow osc
      wr(8'h44, 32'h5);
      wr(8'h84, 32'h0);
      wr(8'hC4, 32'h1);
      for (int d = 1; d < 5; d++) begin
         wr(8'h04, 32'(d));
         repeat (4) @(posedge i_clk);
         tk = '{0, 0, 0};
         repeat (256) begin
            @(posedge i_clk);
            for (int c = 0; c < 3; c++)
               if (o_chan_clk_tick[c] === 1'b1) tk[c]++;
         end
         `CHK("tick div", 256 >> (2 * d - 1), tk[0])
         `CHK("tick none", 0, tk[1])
         `CHK("tick slow", 16, tk[2])
      end
      // Pins one and two clock channels 1 and 2 through inputs 1 and 2
      i_ext_clock_pin <= 3'h0;
      wr(8'h84, 32'h7);
      wr(8'h44, 32'h6);
      tk = '{0, 0, 0};
      for (int i = 0; i < 64; i++) begin
         @(posedge i_clk);
         i_ext_clock_pin <= (i % 16 < 8) ? 3'h6 : 3'h0;
         for (int c = 1; c < 3; c++)
            if (o_chan_clk_tick[c] === 1'b1) tk[c]++;
      end
      `CHK("tick ext1", 4, tk[1])
      `CHK("tick ext2", 4, tk[2])
      // Unmapped place and a write-only register
      rdc(8'h3C, 32'h0, "unmapped");
      `CHK("pslverr", 1'b1, err)
      rdc(8'h24, 32'h0, "wo read");
      `CHK("no err", 1'b0, err)
      `CHK("pready", 1'b1, o_pready)
      wrap_up();
   end
endmodule : tcb_top_tb
